/* mic_diag_pkg.sv */
// Purpose: Shared constants and types for the microphone input fault scan configuration.
// Assumes: One 10 MHz system clock; register values are 8 bits wide.
// Notes: Thresholds are carried in millivolts so the analog side needs no decoding.
package mic_diag_pkg;

  // Register offsets and reset values.
  localparam logic [7:0] SCAN_ENABLES_ADDR = 8'h64;
  localparam logic [7:0] SCAN_ENABLES_RST = 8'h00;
  localparam logic [7:0] TERM_BATT_THR_ADDR = 8'h65;
  localparam logic [7:0] TERM_BATT_THR_RST = 8'h37;
  localparam logic [7:0] GND_BIAS_THR_ADDR = 8'h66;
  localparam logic [7:0] GND_BIAS_THR_RST = 8'h87;
  localparam logic [7:0] SCAN_CTRL_ADDR = 8'h67;
  localparam logic [7:0] SCAN_CTRL_RST = 8'hb8;

  // Field positions.
  localparam int CH1_EN_BIT = 7;
  localparam int CH2_EN_BIT = 6;
  localparam int SE_NEG_INCL_BIT = 1;
  localparam int HI_NIB_MSB = 7;
  localparam int HI_NIB_LSB = 4;
  localparam int LO_NIB_MSB = 3;
  localparam int LO_NIB_LSB = 0;
  localparam int REP_MSB = 7;
  localparam int REP_LSB = 6;
  localparam int GEN_DB_MSB = 3;
  localparam int GEN_DB_LSB = 2;
  localparam int BATT_DB_BIT = 1;
  localparam int DOUBLE_BIT = 0;

  // Threshold steps in millivolts.
  localparam int THR_W = 11;
  localparam logic [10:0] TERM_STEP_MV = 11'h01e;
  localparam logic [10:0] BATT_STEP_MV = 11'h01e;
  localparam logic [10:0] GND_STEP_MV = 11'h03c;
  localparam logic [10:0] BIAS_STEP_MV = 11'h01e;

  // Debounce limits in consecutive scans; no debounce means the first hit.
  localparam logic [4:0] DB_16 = 5'h10;
  localparam logic [4:0] DB_8 = 5'h08;
  localparam logic [4:0] DB_4 = 5'h04;
  localparam logic [4:0] DB_NONE = 5'h01;

  // Scan repetition codes and their periods in milliseconds.
  localparam logic [1:0] REP_CONTINUOUS = 2'h0;
  localparam logic [1:0] REP_1MS = 2'h1;
  localparam logic [1:0] REP_4MS = 2'h2;
  localparam logic [3:0] PERIOD_1_MS = 4'h1;
  localparam logic [3:0] PERIOD_4_MS = 4'h4;
  localparam logic [3:0] PERIOD_8_MS = 4'h8;

  // Clock rate and the length of one millisecond in cycles.
  localparam int CLK_FREQ_HZ = 10000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLK_FREQ_HZ / MS_PER_S;

  // Fault type indices.
  localparam int NUM_FAULTS = 4;
  localparam int F_TERM = 0;
  localparam int F_BATT = 1;
  localparam int F_GND = 2;
  localparam int F_BIAS = 3;

  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_REQ = 2'b01,
    SC_RELEASE = 2'b11,
    SC_WAIT = 2'b10
  } scan_state_t;

  typedef struct packed {
    logic [10:0] term;
    logic [10:0] batt;
    logic [10:0] gnd;
    logic [10:0] bias;
  } thresholds_t;

  typedef struct packed {
    logic [3:0] hit;
    logic batt_low;
  } scan_result_t;

  // Threshold in millivolts: code times step, doubled when asked.
  function automatic logic [10:0] thr_mv(input logic [3:0] code, input logic [10:0] step,
                                         input logic dbl);
    logic [10:0] v;
    v = 11'({7'h00, code} * step);
    thr_mv = dbl ? 11'(v << 1) : v;
  endfunction

endpackage

/* mic_fault_debounce.sv */
// Purpose: Counts consecutive scans on which one fault type was seen.
// Assumes: step pulses once per completed scan; limit is at least one.
// Notes: A miss on any scan clears both the count and the flag.
`timescale 1ns/100ps
module mic_fault_debounce
  import mic_diag_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Scan result.
  input wire logic step,
  input wire logic hit,
  input wire logic [4:0] limit,
  // Debounced fault.
  output logic flag
);

  typedef struct packed {
    logic [4:0] cnt;
    logic flag;
  } deb_t;

  deb_t st_reg;
  deb_t st_next;
  logic [4:0] cnt_inc;

  // Count saturates at the limit so a lowered limit takes effect at once.
  always_comb
  begin
    st_next = st_reg;
    cnt_inc = 5'(st_reg.cnt + 5'h01);
    if (step)
    begin
      // RULE13: consecutive hit counting
      if (hit)
      begin
        st_next.cnt = (st_reg.cnt >= limit) ? st_reg.cnt : cnt_inc;
        st_next.flag = (cnt_inc >= limit);
      end
      else
      begin
        st_next.cnt = 5'h00;
        st_next.flag = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign flag = st_reg.flag;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_miss_clears_flag: assert property (step && !hit |=> !flag) // RULE13
    else $error("Fault flag stayed up after a clean scan.");
  a_flag_needs_count: assert property ($rose(flag) |-> // RULE13
    $past(st_reg.cnt) + 5'h01 >= $past(limit))
    else $error("Fault flag rose before enough consecutive hits.");

endmodule // mic_fault_debounce

/* mic_diag_config.sv */
// Purpose: Fault scan configuration registers, scan pacing and fault debounce.
// Assumes: Scan handshake and comparator results arrive from outside the clock domain.
// Notes: Read data appears one cycle after the address; unmapped addresses read zero.
//
// Function
// RULE1: Terminal short threshold is code times 30 mV, reset code 0011b.
// RULE2: Battery short threshold is code times 30 mV, reset code 0111b.
// RULE3: Ground short threshold is code times 60 mV, reset code 1000b.
// RULE4: Bias short threshold is code times 30 mV, reset code 0111b.
// RULE5: Repetition code zero restarts each scan right after the previous one ends.
// RULE6: Codes 1, 2, 3 start a scan every 1, 4, 8 ms; reset 10b.
// RULE7: General debounce 16, 8, 4 scans or none; reset 10b.
// RULE8: Battery short below bias rail debounces 16 or 8 scans; reset 0.
// RULE9: Doubling bit set multiplies every threshold by two; reset 0.
// RULE10: Software writes 11b into the two reserved scan control bits.
// RULE11: Per-channel enables choose which channels are scanned; both reset to 0.
// RULE12: Selection bit includes or excludes single-ended channels' negative pins.
// RULE13: A fault is reported after the debounce count of consecutive detections.
// RULE14: Unlisted threshold codes continue the same linear step.
`timescale 1ns/100ps
module mic_diag_config
  import mic_diag_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Register port.
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  output logic [7:0] REG_RDATA,
  // Channel configuration from the input stage.
  input wire logic [1:0] SINGLE_ENDED,
  // Scan handshake with the analog scanner.
  output logic SCAN_REQ,
  output logic [3:0] SCAN_PINS,
  input wire logic SCAN_DONE,
  input wire scan_result_t SCAN_RESULT,
  // Thresholds and debounced faults.
  output thresholds_t THRESHOLDS,
  output logic [3:0] FAULT_FLAGS
);
  typedef struct packed {
    logic [7:0] enables;
    logic [7:0] term_batt;
    logic [7:0] gnd_bias;
    logic [7:0] ctrl;
    logic [7:0] rdata;
    scan_state_t st;
    logic [23:0] ms_cnt;
    logic [3:0] ms_elapsed;
    logic req;
    logic [3:0] pins;
    thresholds_t thr;
    logic done_s1;
    logic done_s2;
    scan_result_t res_s1;
    scan_result_t res_s2;
  } core_t;
  localparam logic [23:0] MS_LAST = 24'(MS_CYCLES - 1);
  // Reset thresholds follow from the reset codes with doubling off.
  localparam thresholds_t THR_RST = '{
    term: thr_mv(TERM_BATT_THR_RST[HI_NIB_MSB:HI_NIB_LSB], TERM_STEP_MV, 1'b0),
    batt: thr_mv(TERM_BATT_THR_RST[LO_NIB_MSB:LO_NIB_LSB], BATT_STEP_MV, 1'b0),
    gnd: thr_mv(GND_BIAS_THR_RST[HI_NIB_MSB:HI_NIB_LSB], GND_STEP_MV, 1'b0),
    bias: thr_mv(GND_BIAS_THR_RST[LO_NIB_MSB:LO_NIB_LSB], BIAS_STEP_MV, 1'b0)
  };
  localparam core_t CORE_RST = '{
    enables: SCAN_ENABLES_RST,
    term_batt: TERM_BATT_THR_RST,
    gnd_bias: GND_BIAS_THR_RST,
    ctrl: SCAN_CTRL_RST,
    rdata: 8'h00,
    st: SC_IDLE,
    ms_cnt: 24'h000000,
    ms_elapsed: 4'h0,
    req: 1'b0,
    pins: 4'h0,
    thr: THR_RST,
    done_s1: 1'b0,
    done_s2: 1'b0,
    res_s1: '0,
    res_s2: '0
  };
  core_t st_reg;
  core_t st_next;
  logic any_en;
  logic [1:0] rep;
  logic [3:0] period;
  logic period_done;
  logic scan_step;
  logic dbl;
  logic [4:0] gen_limit;
  logic [4:0] batt_limit;
  logic [4:0] limits [NUM_FAULTS];
  logic [3:0] flags;
  // Decoded controls, all taken from stored register values.
  always_comb
  begin
    any_en = st_reg.enables[CH1_EN_BIT] | st_reg.enables[CH2_EN_BIT];
    rep = st_reg.ctrl[REP_MSB:REP_LSB];
    // RULE9: doubling select
    dbl = st_reg.ctrl[DOUBLE_BIT];
    // RULE6: period per repetition code
    case (rep)
      REP_1MS: period = PERIOD_1_MS;
      REP_4MS: period = PERIOD_4_MS;
      default: period = PERIOD_8_MS;
    endcase
    period_done = (st_reg.ms_elapsed >= period);
    scan_step = (st_reg.st == SC_REQ) && st_reg.done_s2;
    // RULE7: general debounce selection
    case (st_reg.ctrl[GEN_DB_MSB:GEN_DB_LSB])
      2'h0: gen_limit = DB_16;
      2'h1: gen_limit = DB_8;
      2'h2: gen_limit = DB_4;
      default: gen_limit = DB_NONE;
    endcase
    // RULE8: battery short below the bias rail
    batt_limit = st_reg.res_s2.batt_low ? (st_reg.ctrl[BATT_DB_BIT] ? DB_8 : DB_16) : gen_limit;
    limits[F_TERM] = gen_limit;
    limits[F_BATT] = batt_limit;
    limits[F_GND] = gen_limit;
    limits[F_BIAS] = gen_limit;
  end
  // Next state: registers, synchronisers, thresholds, pin selection and scan pacing.
  always_comb
  begin
    st_next = st_reg;
    // Handshake and results are asynchronous, so each passes two flops first.
    st_next.done_s1 = SCAN_DONE;
    st_next.done_s2 = st_reg.done_s1;
    st_next.res_s1 = SCAN_RESULT;
    st_next.res_s2 = st_reg.res_s1;
    // Reserved bits are stored as written; software keeps them at their reset value.
    if (REG_WR)
    begin
      case (REG_ADDR)
        SCAN_ENABLES_ADDR: st_next.enables = REG_WDATA;
        TERM_BATT_THR_ADDR: st_next.term_batt = REG_WDATA;
        GND_BIAS_THR_ADDR: st_next.gnd_bias = REG_WDATA;
        SCAN_CTRL_ADDR: st_next.ctrl = REG_WDATA;
        default: st_next.rdata = st_reg.rdata;
      endcase
    end
    case (REG_ADDR)
      SCAN_ENABLES_ADDR: st_next.rdata = st_reg.enables;
      TERM_BATT_THR_ADDR: st_next.rdata = st_reg.term_batt;
      GND_BIAS_THR_ADDR: st_next.rdata = st_reg.gnd_bias;
      SCAN_CTRL_ADDR: st_next.rdata = st_reg.ctrl;
      default: st_next.rdata = 8'h00;
    endcase
    // RULE14: linear threshold codes
    // RULE1: terminal short step
    st_next.thr.term = thr_mv(st_reg.term_batt[HI_NIB_MSB:HI_NIB_LSB], TERM_STEP_MV, dbl);
    // RULE2: battery short step
    st_next.thr.batt = thr_mv(st_reg.term_batt[LO_NIB_MSB:LO_NIB_LSB], BATT_STEP_MV, dbl);
    // RULE3: ground short step
    st_next.thr.gnd = thr_mv(st_reg.gnd_bias[HI_NIB_MSB:HI_NIB_LSB], GND_STEP_MV, dbl);
    // RULE4: bias short step
    st_next.thr.bias = thr_mv(st_reg.gnd_bias[LO_NIB_MSB:LO_NIB_LSB], BIAS_STEP_MV, dbl);
    // RULE11: enabled channels only
    st_next.pins[0] = st_reg.enables[CH1_EN_BIT];
    st_next.pins[2] = st_reg.enables[CH2_EN_BIT];
    // RULE12: single-ended negative pins
    st_next.pins[1] = st_reg.enables[CH1_EN_BIT]
                      & (~SINGLE_ENDED[0] | st_reg.enables[SE_NEG_INCL_BIT]);
    st_next.pins[3] = st_reg.enables[CH2_EN_BIT]
                      & (~SINGLE_ENDED[1] | st_reg.enables[SE_NEG_INCL_BIT]);
    // One-millisecond enable pulse paces the scans; elapsed count saturates.
    if (st_reg.ms_cnt == MS_LAST)
    begin
      st_next.ms_cnt = 24'h000000;
      if (st_reg.ms_elapsed != 4'hf)
        st_next.ms_elapsed = 4'(st_reg.ms_elapsed + 4'h1);
    end
    else
      st_next.ms_cnt = 24'(st_reg.ms_cnt + 24'h000001);
    // Scan sequencing; the period is measured from the start of each scan.
    case (st_reg.st)
      SC_IDLE:
      begin
        if (any_en)
        begin
          st_next.st = SC_REQ;
          st_next.req = 1'b1;
          st_next.ms_cnt = 24'h000000;
          st_next.ms_elapsed = 4'h0;
        end
      end
      SC_REQ:
      begin
        if (st_reg.done_s2)
        begin
          st_next.st = SC_RELEASE;
          st_next.req = 1'b0;
        end
      end
      SC_RELEASE:
      begin
        if (!st_reg.done_s2)
        begin
          if (!any_en)
            st_next.st = SC_IDLE;
          // RULE5: back to back scans
          else if (rep == REP_CONTINUOUS || period_done)
          begin
            st_next.st = SC_REQ;
            st_next.req = 1'b1;
            st_next.ms_cnt = 24'h000000;
            st_next.ms_elapsed = 4'h0;
          end
          else
            st_next.st = SC_WAIT;
        end
      end
      SC_WAIT:
      begin
        if (!any_en)
          st_next.st = SC_IDLE;
        // RULE6: start at period end
        else if (period_done)
        begin
          st_next.st = SC_REQ;
          st_next.req = 1'b1;
          st_next.ms_cnt = 24'h000000;
          st_next.ms_elapsed = 4'h0;
        end
      end
      default: st_next.st = SC_IDLE;
    endcase
  end
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      st_reg <= CORE_RST;
    else
      st_reg <= st_next;
  end
  // One debouncer per fault type, stepped once per finished scan.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FAULTS; gi++)
    begin : g_deb
      mic_fault_debounce u_deb (
        .clk(CLK_SYS),
        .reset(RESET),
        .step(scan_step),
        .hit(st_reg.res_s2.hit[gi]),
        .limit(limits[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate
  assign REG_RDATA = st_reg.rdata;
  assign SCAN_REQ = st_reg.req;
  assign SCAN_PINS = st_reg.pins;
  assign THRESHOLDS = st_reg.thr;
  assign FAULT_FLAGS = flags;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence s_scan_end;
    st_reg.st == SC_RELEASE && !st_reg.done_s2;
  endsequence
  a_term_threshold: assert property (THRESHOLDS.term == // RULE1
    11'(11'h01e * $past(st_reg.term_batt[7:4]) << $past(st_reg.ctrl[0])))
    else $error("Terminal short threshold does not match its code.");
  a_batt_threshold: assert property (!$past(st_reg.ctrl[0]) |-> // RULE2
    THRESHOLDS.batt == 11'(11'h01e * $past(st_reg.term_batt[3:0])))
    else $error("Battery short threshold does not match its code.");
  a_gnd_threshold: assert property (!$past(st_reg.ctrl[0]) |-> // RULE3
    THRESHOLDS.gnd == 11'(11'h03c * $past(st_reg.gnd_bias[7:4])))
    else $error("Ground short threshold does not match its code.");
  a_bias_doubled: assert property ($past(st_reg.ctrl[0]) |-> // RULE9
    THRESHOLDS.bias == 11'(11'h03c * $past(st_reg.gnd_bias[3:0])))
    else $error("Doubled bias short threshold is wrong.");
  a_continuous_restart: assert property (s_scan_end ##0 (any_en && rep == 2'h0) |=> // RULE5
    st_reg.st == SC_REQ && SCAN_REQ)
    else $error("Continuous mode left a gap between scans.");
  a_period_wait: assert property (st_reg.st == SC_WAIT && !period_done |=> !SCAN_REQ) // RULE6
    else $error("Scan started before its period ran out.");
  a_gen_debounce: assert property (st_reg.ctrl[3:2] == 2'h2 |-> limits[F_GND] == 5'h04) // RULE7
    else $error("General debounce count is wrong.");
  a_batt_debounce: assert property (st_reg.res_s2.batt_low && st_reg.ctrl[1] // RULE8
    |-> limits[F_BATT] == 5'h08)
    else $error("Battery short debounce count is wrong.");
  a_channel_enable: assert property (!$past(st_reg.enables[7]) |-> SCAN_PINS[1:0] == 2'h0) // RULE11
    else $error("Disabled channel pins were selected.");
  a_se_neg_exclude: assert property ($past(SINGLE_ENDED[1]) && !$past(st_reg.enables[1]) // RULE12
    |-> !SCAN_PINS[3])
    else $error("Single-ended negative pin was scanned while excluded.");
endmodule // mic_diag_config

/* test_mic_diag_config.sv */
// Purpose: Self-checking bench for the fault scan configuration block.
// Assumes: MS_CYCLES shortened to 20 so one millisecond lasts 20 clock cycles.
// Notes: The bench plays the analog scanner and answers every scan at once.
`timescale 1ns/100ps
module test_mic_diag_config
  import mic_diag_pkg::*;
;
  localparam int MS = 20;
  localparam int LIMIT = 20000;
  logic CLK_SYS, RESET, REG_WR;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic [1:0] SINGLE_ENDED;
  logic SCAN_REQ, SCAN_DONE;
  logic [3:0] SCAN_PINS, FAULT_FLAGS, pins_seen;
  scan_result_t SCAN_RESULT;
  thresholds_t THRESHOLDS;
  int n_mismatch, tests_run, cyc, t_rise, t_prev;

  mic_diag_config #(.MS_CYCLES(MS)) i_dut (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA),
    .SINGLE_ENDED(SINGLE_ENDED), .SCAN_REQ(SCAN_REQ), .SCAN_PINS(SCAN_PINS),
    .SCAN_DONE(SCAN_DONE), .SCAN_RESULT(SCAN_RESULT), .THRESHOLDS(THRESHOLDS),
    .FAULT_FLAGS(FAULT_FLAGS));

  // Free-running clock at 10 MHz.
  initial
  begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end

  // Cycle counter; a hang past the ceiling counts as a mismatch and ends the run.
  always @(posedge CLK_SYS)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end

  // Compares one value and reports a difference at once.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Synchronous reset held over several edges; inputs move 10 ns after each edge.
  task automatic do_reset();
    @(posedge CLK_SYS);
    #10 RESET = 1'b1;
    repeat (5) @(posedge CLK_SYS);
    #10 RESET = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    #10 REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(posedge CLK_SYS);
    #10 REG_WR = 1'b0;
  endtask

  // Read data is registered one cycle after the address is presented.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK_SYS);
    #10 REG_ADDR = a;
    @(posedge CLK_SYS);
    #10 d = REG_RDATA;
  endtask

  // Plays one scan: waits for a request, returns the result and completes the handshake.
  task automatic scan(input logic [3:0] h, input logic bl);
    int n;
    n = 0;
    while (SCAN_REQ !== 1'b1 && n < 400)
    begin
      @(posedge CLK_SYS);
      #10 n = n + 1;
    end
    check(n < 400, 1'b1);
    t_prev = t_rise;
    t_rise = cyc;
    pins_seen = SCAN_PINS;
    SCAN_RESULT = {h, bl};
    @(posedge CLK_SYS);
    #10 SCAN_DONE = 1'b1;
    n = 0;
    while (SCAN_REQ !== 1'b0 && n < 20)
    begin
      @(posedge CLK_SYS);
      #10 n = n + 1;
    end
    check(n < 20, 1'b1);
    SCAN_DONE = 1'b0;
  endtask

  // Expected threshold worked out independently of the design.
  function automatic logic [10:0] thr(input logic [3:0] c, input logic [10:0] s, input logic d);
    logic [10:0] v;
    v = 11'(c * s);
    thr = d ? 11'(v * 2) : v;
  endfunction

  // Reset values, unmapped access and the idle scanner with both channels off.
  task automatic test_reset();
    logic [7:0] d;
    do_reset();
    rd(SCAN_ENABLES_ADDR, d); check(d, 8'h00);
    rd(TERM_BATT_THR_ADDR, d); check(d, 8'h37);
    rd(GND_BIAS_THR_ADDR, d); check(d, 8'h87);
    rd(SCAN_CTRL_ADDR, d); check(d, 8'hb8);
    check(THRESHOLDS, {11'h05a, 11'h0d2, 11'h1e0, 11'h0d2});
    wr(8'h70, 8'h5a);
    rd(8'h70, d); check(d, 8'h00);
    repeat (30) @(posedge CLK_SYS);
    #10 check(SCAN_REQ, 1'b0);
    $display("test_reset done");
  endtask

  // Threshold fields at boundary codes, with and without doubling.
  task automatic test_thresholds();
    logic [3:0] codes [3] = '{4'h0, 4'h1, 4'hf};
    logic [3:0] c, k;
    logic [7:0] d;
    do_reset();
    for (int i = 0; i < 6; i++)
    begin
      c = codes[i % 3];
      k = 4'hf - c;
      wr(TERM_BATT_THR_ADDR, {c, k});
      wr(GND_BIAS_THR_ADDR, {k, c});
      // Reserved scan control bits always written as 11b.
      wr(SCAN_CTRL_ADDR, {6'b10_11_10, 1'b0, 1'(i / 3)});
      repeat (2) @(posedge CLK_SYS);
      #10 check(THRESHOLDS.term, thr(c, TERM_STEP_MV, 1'(i / 3)));
      check(THRESHOLDS.batt, thr(k, BATT_STEP_MV, 1'(i / 3)));
      check(THRESHOLDS.gnd, thr(k, GND_STEP_MV, 1'(i / 3)));
      check(THRESHOLDS.bias, thr(c, BIAS_STEP_MV, 1'(i / 3)));
      rd(GND_BIAS_THR_ADDR, d); check(d, {k, c});
    end
    $display("test_thresholds done");
  endtask

  // Each repetition code sets the spacing of scan starts.
  task automatic test_rates();
    int lo [4] = '{1, MS, 4 * MS, 8 * MS};
    int hi [4] = '{12, MS + 2, 4 * MS + 2, 8 * MS + 2};
    for (int r = 0; r < 4; r++)
    begin
      do_reset();
      wr(SCAN_CTRL_ADDR, {2'(r), 6'b11_11_00});
      wr(SCAN_ENABLES_ADDR, 8'h80);
      repeat (3) scan(4'h0, 1'b0);
      check((t_rise - t_prev) >= lo[r] && (t_rise - t_prev) <= hi[r], 1'b1);
    end
    $display("test_rates done");
  endtask

  // General debounce: the flag rises on exactly the Nth consecutive hit, a miss clears it.
  task automatic test_debounce();
    int cnt [4] = '{16, 8, 4, 1};
    do_reset();
    wr(SCAN_ENABLES_ADDR, 8'h80);
    for (int g = 0; g < 4; g++)
    begin
      wr(SCAN_CTRL_ADDR, {4'b0011, 2'(g), 2'b00});
      scan(4'h0, 1'b0);
      for (int k = 1; k <= cnt[g]; k++)
      begin
        scan(4'h4, 1'b0);
        check(FAULT_FLAGS, (k == cnt[g]) ? 4'h4 : 4'h0);
      end
      scan(4'h0, 1'b0);
      check(FAULT_FLAGS, 4'h0);
    end
    check((t_rise - t_prev) <= 12, 1'b1);
    $display("test_debounce done");
  endtask

  // Battery short below the bias rail uses its own count; otherwise the general one.
  task automatic test_batt_debounce();
    int cnt [2] = '{16, 8};
    do_reset();
    wr(SCAN_ENABLES_ADDR, 8'h80);
    for (int b = 0; b < 2; b++)
    begin
      wr(SCAN_CTRL_ADDR, {6'b00_11_11, 1'(b), 1'b0});
      scan(4'h0, 1'b0);
      for (int k = 1; k <= cnt[b]; k++)
      begin
        scan(4'h2, 1'b1);
        check(FAULT_FLAGS, (k == cnt[b]) ? 4'h2 : 4'h0);
      end
      scan(4'h0, 1'b1);
      scan(4'h2, 1'b0);
      check(FAULT_FLAGS, 4'h2);
    end
    $display("test_batt_debounce done");
  endtask

  // Pin selection from the channel enables and the single-ended negative pin choice.
  task automatic test_pins();
    logic [7:0] en [5] = '{8'h80, 8'h40, 8'h40, 8'h42, 8'hc0};
    logic [1:0] se [5] = '{2'b00, 2'b00, 2'b10, 2'b10, 2'b01};
    logic [3:0] pm [5] = '{4'h3, 4'hc, 4'h4, 4'hc, 4'hd};
    for (int i = 0; i < 5; i++)
    begin
      do_reset();
      SINGLE_ENDED = se[i];
      wr(SCAN_CTRL_ADDR, 8'h38);
      wr(SCAN_ENABLES_ADDR, en[i]);
      scan(4'h0, 1'b0);
      check(pins_seen, pm[i]);
    end
    $display("test_pins done");
  endtask

  // Main sequence: every input gets a value at time zero.
  initial
  begin
    n_mismatch = 0;
    tests_run = 0;
    cyc = 0;
    t_rise = 0;
    t_prev = 0;
    RESET = 1'b1;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    SINGLE_ENDED = 2'b00;
    SCAN_DONE = 1'b0;
    SCAN_RESULT = '0;
    test_reset();
    test_thresholds();
    test_rates();
    test_debounce();
    test_batt_debounce();
    test_pins();
    final_report();
  end
endmodule // test_mic_diag_config
